// >>> shared/cps_pkg.sv
// constants and types for the cpu pointer and status unit
package cps_pkg;
  // special register locations in sector 0
  localparam logic [7:0] ADDR_INDIRECT_0 = 8'h00;
  localparam logic [7:0] ADDR_PTR_SECTOR0 = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_A = 8'h02;
  localparam logic [7:0] ADDR_PTR_A_LOW = 8'h03;
  localparam logic [7:0] ADDR_PTR_A_SECTOR = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h05;
  localparam logic [7:0] ADDR_PC_LOW = 8'h06;
  localparam logic [7:0] ADDR_TABLE_PTR_LOW = 8'h07;
  localparam logic [7:0] ADDR_TABLE_READ_HIGH = 8'h08;
  localparam logic [7:0] ADDR_TABLE_PTR_HIGH = 8'h09;
  localparam logic [7:0] ADDR_CPU_FLAGS = 8'h0A;
  localparam logic [7:0] ADDR_INDIRECT_B = 8'h0C;
  localparam logic [7:0] ADDR_PTR_B_LOW = 8'h0D;
  localparam logic [7:0] ADDR_PTR_B_SECTOR = 8'h0E;
  localparam logic [7:0] READ_EMPTY = 8'h00;
  // cpu_flags bit positions
  localparam int FLG_C = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_PDF = 4;
  localparam int FLG_TO = 5;
  localparam int FLG_CZ = 6;
  localparam int FLG_SC = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAGS_SW_MASK = 8'hCF;
  // alu operations
  typedef enum logic [3:0] {
    CPS_OP_NONE = 4'h0,
    CPS_OP_ADD  = 4'h1,
    CPS_OP_ADC  = 4'h2,
    CPS_OP_SUB  = 4'h3,
    CPS_OP_SBC  = 4'h4,
    CPS_OP_AND  = 4'h5,
    CPS_OP_OR   = 4'h6,
    CPS_OP_XOR  = 4'h7,
    CPS_OP_RLC  = 4'h8,
    CPS_OP_RRC  = 4'h9,
    CPS_OP_INC  = 4'hA,
    CPS_OP_DEC  = 4'hB,
    CPS_OP_MOV  = 4'hC
  } cps_op_t;
  // pc write sequencing
  typedef enum logic [0:0] {
    CPS_PC_RUN   = 1'b0,
    CPS_PC_DUMMY = 1'b1
  } cps_pc_state_t;
endpackage

// >>> shared/cps_alu_if.sv
// operand and result bundle between the unit and its alu
`timescale 1ns/1ps
`default_nettype none
interface cps_alu_if;
  import cps_pkg::*;
  cps_op_t    op;
  logic [7:0] a;
  logic [7:0] b;
  logic       c_in;
  logic [7:0] res;
  logic       c_out;
  logic       ac_out;
  logic       ov_out;
  logic       flags_hit;
  logic       cz_ext;
  modport core (output op, a, b, c_in, input res, c_out, ac_out, ov_out, flags_hit, cz_ext);
  modport alu  (input op, a, b, c_in, output res, c_out, ac_out, ov_out, flags_hit, cz_ext);
endinterface
`default_nettype wire

// >>> design/cps_alu.sv
// byte alu producing result and arithmetic flag terms
`timescale 1ns/1ps
`default_nettype none
module cps_alu
  import cps_pkg::*;
(
  // operand side
  cps_alu_if.alu bus
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] bx;
  logic       cin;
  logic       ar;
  logic       c7;

  // add and subtract share one adder; subtract adds the inverse
  always_comb begin
    ar = 1'b1;
    cin = 1'b0;
    bx = bus.b;
    case (bus.op)
      CPS_OP_ADD: begin
        cin = 1'b0;
      end
      CPS_OP_ADC: begin
        cin = bus.c_in;
      end
      CPS_OP_SUB: begin
        bx = ~bus.b;
        cin = 1'b1;
      end
      CPS_OP_SBC: begin
        bx = ~bus.b;
        cin = bus.c_in;
      end
      CPS_OP_INC: begin
        bx = 8'h01;
      end
      CPS_OP_DEC: begin
        bx = 8'hFF;
      end
      default: begin
        ar = 1'b0;
      end
    endcase
    sum = {1'b0, bus.a} + {1'b0, bx} + {8'h00, cin};
    // carry out of low nibble; for subtract this is no-borrow
    nib = {1'b0, bus.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    c7 = bus.a[7] ^ bx[7] ^ sum[7];
    bus.res = bus.a;
    bus.c_out = bus.c_in;
    bus.ac_out = 1'b0;
    bus.ov_out = 1'b0;
    bus.flags_hit = ar;
    bus.cz_ext = 1'b0;
    if (ar) begin
      bus.res = sum[7:0];
      bus.c_out = sum[8];
      bus.ac_out = nib[4];
      bus.ov_out = c7 ^ sum[8];
      bus.cz_ext = (bus.op == CPS_OP_ADC) || (bus.op == CPS_OP_SBC);
    end
    case (bus.op)
      CPS_OP_AND: bus.res = bus.a & bus.b;
      CPS_OP_OR:  bus.res = bus.a | bus.b;
      CPS_OP_XOR: bus.res = bus.a ^ bus.b;
      CPS_OP_RLC: begin
        bus.res = {bus.a[6:0], bus.c_in};
        bus.c_out = bus.a[7];
      end
      CPS_OP_RRC: begin
        bus.res = {bus.c_in, bus.a[7:1]};
        bus.c_out = bus.a[0];
      end
      CPS_OP_MOV: bus.res = bus.b;
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// >>> design/cps_core.sv
// pointer, accumulator, table and status registers of the cpu core
`timescale 1ns/1ps
`default_nettype none
// Operation
// - five pointer registers are real storage, read and written like any register
// - indirect port access is redirected to the location its pointer holds
// - the first indirect port reaches sector 0 only
// - the other two ports take sector from pointer high and offset from low
// - extended accesses use a full address whose upper part selects the sector
// - alu results land in the accumulator, or in the addressed location when to_mem is set; no register to register move
// - writing pc low byte jumps within the page and adds one dummy cycle
// - two table pointers address table reads; software loads them first
// - table read puts the word's high byte into the table high register
// - software writes to flags never change power-down or time-out
// - time-out flag: cleared by reset, clear or halt; set by watchdog expiry
// - power-down flag: cleared by reset or clear; set by halt
// - carry set on add carry or subtract no-borrow; rotates update it
// - half carry on low nibble carry, or no nibble borrow when subtracting
// - zero flag set when the operation result is zero
// - overflow when carry into msb differs from carry out of it
// - signed compare flag is overflow xor result msb
// - flags are never saved automatically on interrupt or call
// - indirect ports hold no storage; reached through a pointer they read 00H, writes ignored
module cps_core
  import cps_pkg::*;
#(
  parameter int SECTOR_BITS = 8,
  parameter int PC_BITS     = 13
) (
  // clock and reset
  input  wire logic                           ref_clk_in,
  input  wire logic                           reset_n_in,
  // instruction step
  input  wire logic                           op_valid_in,
  input  wire cps_op_t                        op_code_in,
  input  wire logic                           op_ext_in,
  input  wire logic [SECTOR_BITS+7:0]         op_addr_in,
  input  wire logic                           op_use_mem_in,
  input  wire logic [7:0]                     op_imm_in,
  input  wire logic                           op_to_mem_in,
  input  wire logic                           op_table_read_in,
  input  wire logic [15:0]                    table_word_in,
  // system events
  input  wire logic                           watchdog_clear_instr_in,
  input  wire logic                           halt_instr_in,
  input  wire logic                           watchdog_expired_in,
  // data memory port
  input  wire logic [7:0]                     mem_rdata_in,
  output logic      [SECTOR_BITS+7:0]         mem_addr_out,
  output logic      [7:0]                     mem_wdata_out,
  output logic                                mem_we_out,
  // pc and table port
  output logic                                pc_jump_out,
  output logic      [7:0]                     pc_low_byte_out,
  output logic                                dummy_cycle_out,
  output logic      [15:0]                    table_addr_out,
  // visible state
  output logic      [7:0]                     acc_out,
  output logic      [7:0]                     cpu_flags_out
);
  localparam int AW = SECTOR_BITS + 8;

  cps_alu_if alu_bus ();
  cps_alu u_alu (
    .bus (alu_bus)
  );

  logic [7:0]    ptr_sector0_q, ptr_sector0_d;
  logic [7:0]    ptr_a_low_q, ptr_a_low_d;
  logic [7:0]    ptr_a_sector_q, ptr_a_sector_d;
  logic [7:0]    ptr_b_low_q, ptr_b_low_d;
  logic [7:0]    ptr_b_sector_q, ptr_b_sector_d;
  logic [7:0]    acc_q, acc_d;
  logic [7:0]    table_ptr_low_q, table_ptr_low_d;
  logic [7:0]    table_ptr_high_q, table_ptr_high_d;
  logic [7:0]    table_read_high_q, table_read_high_d;
  logic [7:0]    flags_q, flags_d;
  logic [7:0]    pc_low_q, pc_low_d;
  logic          pc_jump_q, pc_jump_d;
  cps_pc_state_t pc_st_q, pc_st_d;
  logic [AW-1:0] maddr_q, maddr_d;
  logic [7:0]    mwdata_q, mwdata_d;
  logic          mwe_q, mwe_d;
  logic [7:0]    loc;
  logic          is_sfr;
  logic          is_ind;
  logic          ind_empty;
  logic [AW-1:0] eff;
  logic [7:0]    operand;
  logic [7:0]    sfr_rd;
  logic [7:0]    res;
  logic          go;

  // effective address: direct, extended or through a pointer
  always_comb begin
    loc = op_addr_in[7:0];
    is_sfr = !op_ext_in || (op_addr_in[AW-1:8] == '0);
    is_ind = 1'b0;
    eff = op_ext_in ? op_addr_in : {{SECTOR_BITS{1'b0}}, loc};
    if (is_sfr) begin
      case (loc)
        ADDR_INDIRECT_0: begin
          eff = {{SECTOR_BITS{1'b0}}, ptr_sector0_q};
          is_ind = 1'b1;
        end
        ADDR_INDIRECT_A: begin
          eff = {ptr_a_sector_q[SECTOR_BITS-1:0], ptr_a_low_q};
          is_ind = 1'b1;
        end
        ADDR_INDIRECT_B: begin
          eff = {ptr_b_sector_q[SECTOR_BITS-1:0], ptr_b_low_q};
          is_ind = 1'b1;
        end
        default: ;
      endcase
    end
    // a pointer aimed at an indirect port reaches no storage
    ind_empty = is_ind && (eff[AW-1:8] == '0) &&
                ((eff[7:0] == ADDR_INDIRECT_0) || (eff[7:0] == ADDR_INDIRECT_A) ||
                 (eff[7:0] == ADDR_INDIRECT_B));
  end

  // read of special registers; indirect ports read the target location
  always_comb begin
    case (loc)
      ADDR_PTR_SECTOR0:     sfr_rd = ptr_sector0_q;
      ADDR_PTR_A_LOW:       sfr_rd = ptr_a_low_q;
      ADDR_PTR_A_SECTOR:    sfr_rd = ptr_a_sector_q;
      ADDR_PTR_B_LOW:       sfr_rd = ptr_b_low_q;
      ADDR_PTR_B_SECTOR:    sfr_rd = ptr_b_sector_q;
      ADDR_ACC:             sfr_rd = acc_q;
      ADDR_PC_LOW:          sfr_rd = pc_low_q;
      ADDR_TABLE_PTR_LOW:   sfr_rd = table_ptr_low_q;
      ADDR_TABLE_PTR_HIGH:  sfr_rd = table_ptr_high_q;
      ADDR_TABLE_READ_HIGH: sfr_rd = table_read_high_q;
      ADDR_CPU_FLAGS:       sfr_rd = flags_q;
      default:              sfr_rd = mem_rdata_in;
    endcase
    if (!op_use_mem_in) begin
      operand = op_imm_in;
    end else if (is_sfr && !is_ind) begin
      operand = sfr_rd;
    end else if (ind_empty) begin
      operand = READ_EMPTY;
    end else begin
      operand = mem_rdata_in;
    end
  end

  // alu operands: accumulator with memory, or memory alone for inc, dec and rotates
  always_comb begin
    go = op_valid_in && (pc_st_q == CPS_PC_RUN);
    alu_bus.op = op_code_in;
    alu_bus.c_in = flags_q[FLG_C];
    if ((op_code_in == CPS_OP_INC) || (op_code_in == CPS_OP_DEC) ||
        (op_code_in == CPS_OP_RLC) || (op_code_in == CPS_OP_RRC)) begin
      alu_bus.a = operand;
    end else begin
      alu_bus.a = acc_q;
    end
    alu_bus.b = operand;
    res = alu_bus.res;
  end

  // next state of registers for one instruction step
  always_comb begin
    ptr_sector0_d = ptr_sector0_q;
    ptr_a_low_d = ptr_a_low_q;
    ptr_a_sector_d = ptr_a_sector_q;
    ptr_b_low_d = ptr_b_low_q;
    ptr_b_sector_d = ptr_b_sector_q;
    acc_d = acc_q;
    table_ptr_low_d = table_ptr_low_q;
    table_ptr_high_d = table_ptr_high_q;
    table_read_high_d = table_read_high_q;
    flags_d = flags_q;
    pc_low_d = pc_low_q;
    pc_jump_d = 1'b0;
    pc_st_d = CPS_PC_RUN;
    maddr_d = eff;
    mwdata_d = res;
    mwe_d = 1'b0;
    if (go) begin
      if (op_table_read_in) begin
        table_read_high_d = table_word_in[15:8];
        mwdata_d = table_word_in[7:0];
      end
      if (op_table_read_in || op_to_mem_in) begin
        if (is_sfr && !is_ind) begin
          case (loc)
            ADDR_PTR_SECTOR0:     ptr_sector0_d = mwdata_d;
            ADDR_PTR_A_LOW:       ptr_a_low_d = mwdata_d;
            ADDR_PTR_A_SECTOR:    ptr_a_sector_d = mwdata_d;
            ADDR_PTR_B_LOW:       ptr_b_low_d = mwdata_d;
            ADDR_PTR_B_SECTOR:    ptr_b_sector_d = mwdata_d;
            ADDR_ACC:             acc_d = mwdata_d;
            ADDR_TABLE_PTR_LOW:   table_ptr_low_d = mwdata_d;
            ADDR_TABLE_PTR_HIGH:  table_ptr_high_d = mwdata_d;
            ADDR_TABLE_READ_HIGH: table_read_high_d = mwdata_d;
            ADDR_PC_LOW: begin
              pc_low_d = mwdata_d;
              pc_jump_d = 1'b1;
              pc_st_d = CPS_PC_DUMMY;
            end
            ADDR_CPU_FLAGS: flags_d = (mwdata_d & FLAGS_SW_MASK) |
                                      (flags_q & ~FLAGS_SW_MASK);
            default: mwe_d = 1'b1;
          endcase
        end else begin
          mwe_d = !ind_empty;
        end
      end else if (op_code_in != CPS_OP_NONE) begin
        acc_d = res;
      end
      // arithmetic flags follow the latest operation
      if (!op_table_read_in && (op_code_in != CPS_OP_NONE) && (op_code_in != CPS_OP_MOV)) begin
        flags_d[FLG_Z] = (res == 8'h00);
        if (alu_bus.flags_hit || op_code_in == CPS_OP_RLC || op_code_in == CPS_OP_RRC) begin
          flags_d[FLG_C] = alu_bus.c_out;
        end
        if (alu_bus.flags_hit) begin
          flags_d[FLG_AC] = alu_bus.ac_out;
          flags_d[FLG_OV] = alu_bus.ov_out;
          flags_d[FLG_SC] = alu_bus.ov_out ^ res[7];
          if (alu_bus.cz_ext) begin
            flags_d[FLG_CZ] = flags_q[FLG_CZ] & (res == 8'h00);
          end else if (op_code_in == CPS_OP_SUB) begin
            flags_d[FLG_CZ] = (res == 8'h00);
          end
        end
      end
    end
    // system flags; event set wins over clear in the same cycle
    if (watchdog_clear_instr_in || halt_instr_in) begin
      flags_d[FLG_TO] = 1'b0;
    end
    if (watchdog_expired_in) begin
      flags_d[FLG_TO] = 1'b1;
    end
    if (watchdog_clear_instr_in) begin
      flags_d[FLG_PDF] = 1'b0;
    end
    if (halt_instr_in) begin
      flags_d[FLG_PDF] = 1'b1;
    end
  end

  // registers; flags are plain storage, nothing pushes them
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      ptr_sector0_q <= 8'h00;
      ptr_a_low_q <= 8'h00;
      ptr_a_sector_q <= 8'h00;
      ptr_b_low_q <= 8'h00;
      ptr_b_sector_q <= 8'h00;
      acc_q <= 8'h00;
      table_ptr_low_q <= 8'h00;
      table_ptr_high_q <= 8'h00;
      table_read_high_q <= 8'h00;
      flags_q <= FLAGS_RESET;
      pc_low_q <= 8'h00;
      pc_jump_q <= 1'b0;
      pc_st_q <= CPS_PC_RUN;
      maddr_q <= '0;
      mwdata_q <= 8'h00;
      mwe_q <= 1'b0;
    end else begin
      ptr_sector0_q <= ptr_sector0_d;
      ptr_a_low_q <= ptr_a_low_d;
      ptr_a_sector_q <= ptr_a_sector_d;
      ptr_b_low_q <= ptr_b_low_d;
      ptr_b_sector_q <= ptr_b_sector_d;
      acc_q <= acc_d;
      table_ptr_low_q <= table_ptr_low_d;
      table_ptr_high_q <= table_ptr_high_d;
      table_read_high_q <= table_read_high_d;
      flags_q <= flags_d;
      pc_low_q <= pc_low_d;
      pc_jump_q <= pc_jump_d;
      pc_st_q <= pc_st_d;
      maddr_q <= maddr_d;
      mwdata_q <= mwdata_d;
      mwe_q <= mwe_d;
    end
  end

  // outputs straight from flops
  assign mem_addr_out = maddr_q;
  assign mem_wdata_out = mwdata_q;
  assign mem_we_out = mwe_q;
  assign pc_jump_out = pc_jump_q;
  assign pc_low_byte_out = pc_low_q;
  assign dummy_cycle_out = (pc_st_q == CPS_PC_DUMMY);
  assign table_addr_out = {table_ptr_high_q, table_ptr_low_q};
  assign acc_out = acc_q;
  assign cpu_flags_out = flags_q;

  // checks
  a_swwrite_keeps_sys: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (go && op_to_mem_in && !op_table_read_in && is_sfr && !is_ind && loc == ADDR_CPU_FLAGS &&
     !watchdog_clear_instr_in && !halt_instr_in && !watchdog_expired_in)
    |=> (cpu_flags_out[5:4] == $past(cpu_flags_out[5:4])))
    else $error("software write changed system flags");
  a_timeout_set: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    watchdog_expired_in |=> cpu_flags_out[FLG_TO])
    else $error("time-out flag not set");
  a_halt_pdf: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    halt_instr_in |=> cpu_flags_out[FLG_PDF])
    else $error("power-down flag not set by halt");
  a_clear_pdf: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (watchdog_clear_instr_in && !halt_instr_in) |=> !cpu_flags_out[FLG_PDF])
    else $error("power-down flag not cleared");
  a_pc_dummy: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    pc_jump_out |-> dummy_cycle_out ##1 !dummy_cycle_out)
    else $error("pc write without one dummy cycle");
  a_sc_relation: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (go && alu_bus.flags_hit && !op_table_read_in && !op_to_mem_in)
    |=> cpu_flags_out[FLG_SC] == (cpu_flags_out[FLG_OV] ^ acc_out[7]))
    else $error("signed compare flag mismatch");
  a_zero_flag: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (go && !op_to_mem_in && !op_table_read_in && op_code_in != CPS_OP_NONE && op_code_in != CPS_OP_MOV)
    |=> cpu_flags_out[FLG_Z] == (acc_out == 8'h00))
    else $error("zero flag mismatch");
  a_ind0_sector0: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (go && op_to_mem_in && !op_ext_in && loc == ADDR_INDIRECT_0 && !ind_empty)
    |=> mem_we_out && mem_addr_out[AW-1:8] == '0)
    else $error("indirect port 0 left sector 0");
  a_ind_empty_write: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (go && (op_to_mem_in || op_table_read_in) && ind_empty) |=> !mem_we_out)
    else $error("write through pointer reached an indirect port");
  a_table_high: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (go && op_table_read_in && !(is_sfr && !is_ind && loc == ADDR_TABLE_READ_HIGH))
    |=> table_read_high_q == $past(table_word_in[15:8]))
    else $error("table high byte not captured");
endmodule
`default_nettype wire

// >>> bench/cps_core_bench.sv
// self-checking bench for the cpu pointer and status unit
`timescale 1ns/1ps
`default_nettype none
module cps_core_bench;
  import cps_pkg::*;
  // operand routing codes {ext, use_mem, to_mem}
  localparam logic [2:0] IMM_ACC = 3'b000;
  localparam logic [2:0] IMM_MEM = 3'b001;
  localparam logic [2:0] MEM_ACC = 3'b010;
  localparam logic [2:0] MEM_MEM = 3'b011;
  localparam logic [2:0] EXT_MEM = 3'b101;
  localparam logic [2:0] EXT_ACC = 3'b110;
  typedef struct {cps_op_t op; logic [7:0] a; logic [7:0] b; logic [7:0] r; logic [7:0] f; logic [7:0] m;} cps_row_t;
  // stimulus
  logic          ref_clk_in;
  logic          reset_n_in;
  logic          op_valid_in;
  cps_op_t       op_code_in;
  logic          op_ext_in;
  logic   [15:0] op_addr_in;
  logic          op_use_mem_in;
  logic   [7:0]  op_imm_in;
  logic          op_to_mem_in;
  logic          op_table_read_in;
  logic   [15:0] table_word_in;
  logic          watchdog_clear_instr_in;
  logic          halt_instr_in;
  logic          watchdog_expired_in;
  logic   [7:0]  mem_rdata_in;
  // observed outputs
  logic   [15:0] mem_addr_out;
  logic   [7:0]  mem_wdata_out;
  logic          mem_we_out;
  logic          pc_jump_out;
  logic   [7:0]  pc_low_byte_out;
  logic          dummy_cycle_out;
  logic   [15:0] table_addr_out;
  logic   [7:0]  acc_out;
  logic   [7:0]  cpu_flags_out;
  int            fail_count;
  int            checks;
  // alu cases: acc value, operand, result, flags, flag mask
  cps_row_t rows [17] = '{
    '{CPS_OP_ADD, 8'h0F, 8'h01, 8'h10, 8'h02, 8'h8F}, '{CPS_OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h0A, 8'h8F},
    '{CPS_OP_ADD, 8'h80, 8'h80, 8'h00, 8'h8D, 8'h8F}, '{CPS_OP_SUB, 8'h05, 8'h03, 8'h02, 8'h03, 8'hCF},
    '{CPS_OP_SUB, 8'h05, 8'h05, 8'h00, 8'h47, 8'hCF}, '{CPS_OP_AND, 8'hFF, 8'h00, 8'h00, 8'h44, 8'h44},
    '{CPS_OP_SUB, 8'h03, 8'h05, 8'hFE, 8'h80, 8'hCF}, '{CPS_OP_RLC, 8'h00, 8'h80, 8'h00, 8'h01, 8'h01},
    '{CPS_OP_RRC, 8'h00, 8'h02, 8'h81, 8'h00, 8'h01}, '{CPS_OP_SUB, 8'h80, 8'h01, 8'h7F, 8'h89, 8'hCF},
    '{CPS_OP_XOR, 8'h5A, 8'h5A, 8'h00, 8'h04, 8'h04}, '{CPS_OP_SUB, 8'h05, 8'h03, 8'h02, 8'h03, 8'hCF},
    '{CPS_OP_ADC, 8'hFF, 8'h00, 8'h00, 8'h07, 8'hCF}, '{CPS_OP_SUB, 8'h03, 8'h05, 8'hFE, 8'h80, 8'hCF},
    '{CPS_OP_SBC, 8'h05, 8'h04, 8'h00, 8'h07, 8'hCF}, '{CPS_OP_DEC, 8'h00, 8'h01, 8'h00, 8'h04, 8'h04},
    '{CPS_OP_OR, 8'h55, 8'h0F, 8'h5F, 8'h00, 8'h44}};

  cps_core u_dut (
    .ref_clk_in              (ref_clk_in),
    .reset_n_in              (reset_n_in),
    .op_valid_in             (op_valid_in),
    .op_code_in              (op_code_in),
    .op_ext_in               (op_ext_in),
    .op_addr_in              (op_addr_in),
    .op_use_mem_in           (op_use_mem_in),
    .op_imm_in               (op_imm_in),
    .op_to_mem_in            (op_to_mem_in),
    .op_table_read_in        (op_table_read_in),
    .table_word_in           (table_word_in),
    .watchdog_clear_instr_in (watchdog_clear_instr_in),
    .halt_instr_in           (halt_instr_in),
    .watchdog_expired_in     (watchdog_expired_in),
    .mem_rdata_in            (mem_rdata_in),
    .mem_addr_out            (mem_addr_out),
    .mem_wdata_out           (mem_wdata_out),
    .mem_we_out              (mem_we_out),
    .pc_jump_out             (pc_jump_out),
    .pc_low_byte_out         (pc_low_byte_out),
    .dummy_cycle_out         (dummy_cycle_out),
    .table_addr_out          (table_addr_out),
    .acc_out                 (acc_out),
    .cpu_flags_out           (cpu_flags_out)
  );

  // free running clock
  always #4 ref_clk_in = ~ref_clk_in;

  // comparison and verdict
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one instruction step; returns with its answer settled and op_valid_in already dropped
  task automatic step(input cps_op_t op, input logic [15:0] addr, input logic [7:0] imm,
                      input logic [2:0] f, input logic [7:0] rd);
    @(negedge ref_clk_in);
    op_valid_in = 1'b1;
    op_code_in = op;
    op_addr_in = addr;
    op_imm_in = imm;
    {op_ext_in, op_use_mem_in, op_to_mem_in} = f;
    mem_rdata_in = rd;
    @(negedge ref_clk_in);
    op_valid_in = 1'b0;
    mem_rdata_in = ~rd;
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    step(CPS_OP_MOV, {8'h00, a}, v, IMM_MEM, 8'h00);
  endtask
  // system event pulse {clear, halt, expiry}
  task automatic pulse(input logic [2:0] e);
    @(negedge ref_clk_in);
    {watchdog_clear_instr_in, halt_instr_in, watchdog_expired_in} = e;
    @(negedge ref_clk_in);
    {watchdog_clear_instr_in, halt_instr_in, watchdog_expired_in} = 3'b000;
  endtask

  // scenarios
  task automatic t_reset;
    chk(cpu_flags_out, FLAGS_RESET);
    chk({acc_out, table_addr_out[7:0]}, 16'h0000);
  endtask
  task automatic t_alu;
    foreach (rows[i]) begin
      step(CPS_OP_MOV, 16'h0000, rows[i].a, IMM_ACC, 8'h00);
      step(rows[i].op, 16'h0000, rows[i].b, IMM_ACC, 8'h00);
      chk(acc_out, rows[i].r);
      chk(cpu_flags_out & rows[i].m, rows[i].f);
      chk(mem_we_out, 1'b0);
    end
  endtask
  task automatic t_flags;
    put(ADDR_CPU_FLAGS, 8'hFF);
    chk(cpu_flags_out, FLAGS_SW_MASK);
    pulse(3'b001);
    chk(cpu_flags_out & 8'h30, 8'h20);
    pulse(3'b010);
    chk(cpu_flags_out & 8'h30, 8'h10);
    pulse(3'b001);
    put(ADDR_CPU_FLAGS, 8'h00);
    chk(cpu_flags_out, 8'h30);
    pulse(3'b100);
    chk(cpu_flags_out, 8'h00);
    // expiry beats clear, halt beats clear
    pulse(3'b101);
    chk(cpu_flags_out & 8'h30, 8'h20);
    pulse(3'b110);
    chk(cpu_flags_out & 8'h30, 8'h10);
  endtask
  task automatic t_pointers;
    put(ADDR_PTR_SECTOR0, 8'h40);
    put(ADDR_INDIRECT_0, 8'h5A);
    chk({mem_we_out, mem_wdata_out, mem_addr_out[15:8]}, 17'h15A00);
    chk(mem_addr_out, 16'h0040);
    put(ADDR_PTR_A_LOW, 8'hF0);
    put(ADDR_PTR_A_SECTOR, 8'h01);
    put(ADDR_INDIRECT_A, 8'h11);
    chk(mem_addr_out, 16'h01F0);
    put(ADDR_PTR_B_LOW, 8'h22);
    put(ADDR_PTR_B_SECTOR, 8'h03);
    put(ADDR_INDIRECT_B, 8'h33);
    chk(mem_addr_out, 16'h0322);
    step(CPS_OP_MOV, {8'h00, ADDR_PTR_A_LOW}, 8'h00, MEM_ACC, 8'hA5);
    chk(acc_out, 8'hF0);
    put(ADDR_PTR_A_LOW, 8'hFF);
    step(CPS_OP_INC, {8'h00, ADDR_PTR_A_LOW}, 8'h00, MEM_MEM, 8'hA5);
    step(CPS_OP_MOV, {8'h00, ADDR_INDIRECT_A}, 8'h00, MEM_ACC, 8'h3C);
    chk(mem_addr_out, 16'h0100);
    chk(acc_out, 8'h3C);
    // pointer aimed at an indirect port: reads empty, writes vanish
    put(ADDR_PTR_SECTOR0, ADDR_INDIRECT_A);
    step(CPS_OP_MOV, {8'h00, ADDR_INDIRECT_0}, 8'h00, MEM_ACC, 8'hA5);
    chk(acc_out, READ_EMPTY);
    put(ADDR_INDIRECT_0, 8'h66);
    chk(mem_we_out, 1'b0);
  endtask
  task automatic t_extended;
    step(CPS_OP_MOV, 16'h01F0, 8'h77, EXT_MEM, 8'h00);
    chk({mem_we_out, mem_wdata_out}, 9'h177);
    chk(mem_addr_out, 16'h01F0);
    step(CPS_OP_MOV, 16'h01F0, 8'h00, EXT_ACC, 8'h6B);
    chk(acc_out, 8'h6B);
  endtask
  task automatic t_pc;
    step(CPS_OP_MOV, 16'h0000, 8'h20, IMM_ACC, 8'h00);
    // pc write with valid held into the dummy cycle, whose add must be dropped
    @(negedge ref_clk_in);
    op_valid_in = 1'b1;
    op_code_in = CPS_OP_MOV;
    op_addr_in = {8'h00, ADDR_PC_LOW};
    op_imm_in = 8'h9C;
    {op_ext_in, op_use_mem_in, op_to_mem_in} = IMM_MEM;
    @(negedge ref_clk_in);
    chk({pc_jump_out, dummy_cycle_out, pc_low_byte_out}, 10'h39C);
    op_code_in = CPS_OP_ADD;
    op_imm_in = 8'h01;
    {op_ext_in, op_use_mem_in, op_to_mem_in} = IMM_ACC;
    @(negedge ref_clk_in);
    op_valid_in = 1'b0;
    chk({pc_jump_out, dummy_cycle_out, acc_out}, 10'h020);
  endtask
  task automatic t_table;
    put(ADDR_TABLE_PTR_LOW, 8'h34);
    put(ADDR_TABLE_PTR_HIGH, 8'h12);
    chk(table_addr_out, 16'h1234);
    step(CPS_OP_INC, {8'h00, ADDR_TABLE_PTR_LOW}, 8'h00, MEM_MEM, 8'h00);
    chk(table_addr_out, 16'h1235);
    op_table_read_in = 1'b1;
    table_word_in = 16'hBEEF;
    step(CPS_OP_MOV, 16'h0020, 8'h00, IMM_MEM, 8'h00);
    op_table_read_in = 1'b0;
    chk({mem_we_out, mem_wdata_out}, 9'h1EF);
    chk(mem_addr_out, 16'h0020);
    step(CPS_OP_MOV, {8'h00, ADDR_TABLE_READ_HIGH}, 8'h00, MEM_ACC, 8'h00);
    chk(acc_out, 8'hBE);
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    fail_count++;
    complete_run();
  end
  // main sequence
  initial begin
    ref_clk_in = 1'b0;
    reset_n_in = 1'b0;
    op_valid_in = 1'b0;
    op_code_in = CPS_OP_NONE;
    {op_ext_in, op_use_mem_in, op_to_mem_in, op_table_read_in} = 4'h0;
    op_addr_in = 16'h0000;
    op_imm_in = 8'h00;
    table_word_in = 16'h0000;
    {watchdog_clear_instr_in, halt_instr_in, watchdog_expired_in} = 3'b000;
    mem_rdata_in = 8'hFF;
    fail_count = 0;
    checks = 0;
    repeat (6) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    t_reset();
    t_alu();
    t_flags();
    t_pointers();
    t_extended();
    t_pc();
    t_table();
    complete_run();
  end
endmodule
`default_nettype wire
